// >>> design/iopd_top.sv
// i/o page slave: register decode, byte/word transfers, vectored interrupt, apb side
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - decode only when page select asserted
// - device addresses sit in upper 4k
// - match address bits 15:1 per register, bit 0 picks the byte
// - address taken from muxed lines 15:0
// - word and byte transfers both supported
// - registers answer like ordinary memory locations
// - raise interrupt request when service needed
// - only highest requester drives its vector
// - priority follows position on acknowledge chain
// - each device holds its own vector
// - status bits have fixed functions
module iopd_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [iopd_pkg::APB_AW-1:0] i_paddr,
    input wire logic [iopd_pkg::APB_DW-1:0] i_pwdata,
    output logic [iopd_pkg::APB_DW-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // backplane address and data
    input wire logic [iopd_pkg::ADDR_W-1:0] i_muxed_addr_data_lines,
    output logic [iopd_pkg::ADDR_W-1:0] o_muxed_addr_data_lines,
    output logic o_muxed_addr_data_oe,
    input wire logic i_io_page_select_n,
    // backplane cycle strobes
    input wire logic i_bus_sync,
    input wire logic i_bus_din,
    input wire logic i_bus_dout,
    input wire logic i_bus_byte,
    output logic o_bus_reply,
    // backplane interrupt
    output logic o_bus_irq,
    input wire logic i_bus_iak_in,
    output logic o_bus_iak_out,
    // interrupt to local software
    output logic o_irq
);
    import iopd_pkg::*;

    typedef struct packed {
        iopd_phase_t phase;
        iopd_sel_t sel;
        logic byte_hi;
        logic sync_d;
        logic dout_d;
        logic [WORD_W-1:0] rd_word;
        logic drive;
        logic reply;
        logic ie;
        logic done;
        logic err;
        logic irq_armed;
        logic req_prev;
        logic [WORD_W-1:0] dbuf_in;
        logic [WORD_W-1:0] dbuf_out;
        logic [WORD_W-1:0] base;
        logic [WORD_W-1:0] vector;
        logic [EV_N-1:0] events;
        logic [EV_N-1:0] mask;
        logic [APB_DW-1:0] prdata;
        logic pready;
    } iopd_state_t;

    iopd_state_t st_r;
    iopd_state_t st_nxt;

    logic [WORD_W-1:0] addr_lo;
    logic [WORD_W-1:0] wdata;
    logic [WORD_W-1:0] csw_view;
    logic page_hit;
    logic sync_rise;
    logic dout_rise;
    logic apb_done;
    logic apb_wr;
    logic apb_rd;
    logic [EV_N-1:0] ev_set;
    logic service_req;

    assign addr_lo = i_muxed_addr_data_lines[WORD_W-1:0];
    assign wdata = i_muxed_addr_data_lines[WORD_W-1:0];
    // page select alone marks the i/o page; lines 17:16 are never decoded
    assign page_hit = !i_io_page_select_n;
    assign sync_rise = i_bus_sync && !st_r.sync_d;
    assign dout_rise = i_bus_dout && !st_r.dout_d;
    assign apb_done = i_psel && i_penable && st_r.pready;
    assign apb_wr = apb_done && i_pwrite;
    assign apb_rd = apb_done && !i_pwrite;
    assign service_req = st_r.ie && st_r.done;

    always_comb begin
        csw_view = '0;
        csw_view[CSW_IE] = st_r.ie;
        csw_view[CSW_DONE] = st_r.done;
        csw_view[CSW_ERR] = st_r.err;
    end

    always_comb begin
        st_nxt = st_r;
        ev_set = '0;
        st_nxt.sync_d = i_bus_sync;
        st_nxt.dout_d = i_bus_dout;
        st_nxt.req_prev = service_req;

        // arm the request on each fresh need for service
        if (service_req && !st_r.req_prev) begin
            st_nxt.irq_armed = 1'b1;
        end
        if (!service_req) begin
            st_nxt.irq_armed = 1'b0;
        end

        unique case (st_r.phase)
            IOPD_IDLE: begin
                st_nxt.drive = 1'b0;
                st_nxt.reply = 1'b0;
                st_nxt.sel = IOPD_SEL_NONE;
                if (sync_rise && page_hit) begin
                    // address lives in the low 16 bits only, taken straight off the lines as sync rises
                    st_nxt.byte_hi = addr_lo[0];
                    if (addr_lo[WORD_W-1:1] == st_r.base[WORD_W-1:1]) begin
                        st_nxt.sel = IOPD_SEL_CSW;
                        st_nxt.phase = IOPD_ADDR;
                    end else if (addr_lo[WORD_W-1:1] == st_nxt_dbuf_hi(st_r.base)) begin
                        st_nxt.sel = IOPD_SEL_DBUF;
                        st_nxt.phase = IOPD_ADDR;
                    end
                end else if (!i_bus_sync && i_bus_iak_in && i_bus_din && st_r.irq_armed) begin
                    // acknowledge stops here: this device is the nearest requester
                    st_nxt.rd_word = st_r.vector;
                    st_nxt.drive = 1'b1;
                    st_nxt.reply = 1'b1;
                    st_nxt.irq_armed = 1'b0;
                    ev_set[EV_VECTOR] = 1'b1;
                    st_nxt.phase = IOPD_VEC;
                end
            end
            IOPD_ADDR: begin
                // same read/write cycles as a memory location
                if (!i_bus_sync) begin
                    st_nxt.phase = IOPD_IDLE;
                end else if (i_bus_din) begin
                    st_nxt.rd_word = (st_r.sel == IOPD_SEL_CSW) ? csw_view : st_r.dbuf_out;
                    st_nxt.drive = 1'b1;
                    st_nxt.reply = 1'b1;
                    if (st_r.sel == IOPD_SEL_DBUF) begin
                        ev_set[EV_BUS_READ] = 1'b1;
                    end
                    st_nxt.phase = IOPD_XFER;
                end else if (dout_rise) begin
                    st_nxt.reply = 1'b1;
                    if (st_r.sel == IOPD_SEL_CSW) begin
                        // ie is bit 6, low byte; go raises its event and clears done whether or not ie is set
                        if (!i_bus_byte || !st_r.byte_hi) begin
                            st_nxt.ie = wdata[CSW_IE];
                            if (wdata[CSW_GO]) begin
                                ev_set[EV_GO] = 1'b1;
                                st_nxt.done = 1'b0;
                            end
                        end
                    end else begin
                        if (!i_bus_byte) begin
                            st_nxt.dbuf_in = wdata;
                        end else if (st_r.byte_hi) begin
                            st_nxt.dbuf_in[15:8] = wdata[15:8];
                        end else begin
                            st_nxt.dbuf_in[7:0] = wdata[7:0];
                        end
                        st_nxt.done = 1'b0;
                        ev_set[EV_BUS_WRITE] = 1'b1;
                    end
                    st_nxt.phase = IOPD_XFER;
                end
            end
            IOPD_XFER: begin
                // reply holds until the master drops its strobe
                if (!i_bus_din && !i_bus_dout) begin
                    st_nxt.drive = 1'b0;
                    st_nxt.reply = 1'b0;
                    st_nxt.phase = i_bus_sync ? IOPD_ADDR : IOPD_IDLE;
                end
            end
            IOPD_VEC: begin
                if (!i_bus_din || !i_bus_iak_in) begin
                    st_nxt.drive = 1'b0;
                    st_nxt.reply = 1'b0;
                    st_nxt.phase = IOPD_IDLE;
                end
            end
            default: begin
                st_nxt.phase = IOPD_IDLE;
            end
        endcase

        // apb: one wait state, so read data comes from a flop
        st_nxt.pready = i_psel && i_penable && !st_r.pready;
        if (i_psel && i_penable && !st_r.pready) begin
            unique case (i_paddr)
                RA_EVENT: st_nxt.prdata = APB_DW'(st_r.events);
                RA_MASK: st_nxt.prdata = APB_DW'(st_r.mask);
                RA_BASE: st_nxt.prdata = APB_DW'(st_r.base);
                RA_VECTOR: st_nxt.prdata = APB_DW'(st_r.vector);
                RA_DEVICE: st_nxt.prdata = APB_DW'(csw_view);
                RA_DATA: st_nxt.prdata = APB_DW'(st_r.dbuf_in);
                default: st_nxt.prdata = '0;
            endcase
        end
        if (apb_wr) begin
            unique case (i_paddr)
                RA_MASK: st_nxt.mask = i_pwdata[EV_N-1:0];
                // base is forced into the upper 4k with bits 1:0 cleared
                RA_BASE: st_nxt.base = (i_pwdata[WORD_W-1:0] & ~IO_PAGE_MASK & 16'hfffc) | IO_PAGE_BITS;
                RA_VECTOR: st_nxt.vector = i_pwdata[WORD_W-1:0] & VECTOR_MASK;
                RA_DEVICE: begin
                    if (i_pwdata[DEV_SET_DONE]) begin
                        st_nxt.done = 1'b1;
                    end
                    if (i_pwdata[DEV_CLR_ERR]) begin
                        st_nxt.err = 1'b0;
                    end
                    if (i_pwdata[DEV_SET_ERR]) begin
                        st_nxt.err = 1'b1;
                        st_nxt.done = 1'b1;
                    end
                end
                RA_DATA: st_nxt.dbuf_out = i_pwdata[WORD_W-1:0];
                default: ;
            endcase
        end
        // read clears the events, but a new event in that cycle survives
        if (apb_rd && i_paddr == RA_EVENT) begin
            st_nxt.events = ev_set;
        end else begin
            st_nxt.events = st_r.events | ev_set;
        end
    end

    // second register sits one word above the first
    function automatic logic [WORD_W-2:0] st_nxt_dbuf_hi(input logic [WORD_W-1:0] base);
        logic [WORD_W-1:0] sum;
        sum = base + DBUF_OFFSET;
        return sum[WORD_W-1:1];
    endfunction : st_nxt_dbuf_hi

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_r <= '0;
            st_r.phase <= IOPD_IDLE;
            st_r.sel <= IOPD_SEL_NONE;
            st_r.base <= BASE_ADDR_RST;
            st_r.vector <= VECTOR_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // lines are released whenever this device is not the selected answerer
    assign o_muxed_addr_data_oe = st_r.drive;
    assign o_muxed_addr_data_lines = st_r.drive ? ADDR_W'(st_r.rd_word) : '0;
    assign o_bus_reply = st_r.reply;
    assign o_bus_irq = st_r.irq_armed;
    // grant passes on only when this device is not requesting
    assign o_bus_iak_out = i_bus_iak_in && !st_r.irq_armed && st_r.phase != IOPD_VEC;
    assign o_prdata = st_r.prdata;
    assign o_pready = st_r.pready;
    assign o_pslverr = 1'b0;
    assign o_irq = |(st_r.events & st_r.mask);

endmodule : iopd_top

// >>> design/iopd_pkg.sv
// constants, register map and state types for the i/o page decode and vector reply block
package iopd_pkg;

    // bus widths
    localparam int ADDR_W = 18;
    localparam int WORD_W = 16;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;

    // upper 4k of the address space: bits 15:12 of every device address are ones
    localparam logic [15:0] IO_PAGE_BITS = 16'hf000;
    localparam logic [15:0] IO_PAGE_MASK = 16'hf000;

    // power-up placement of the two device registers and the vector
    localparam logic [15:0] BASE_ADDR_RST = 16'hf100;
    localparam logic [15:0] DBUF_OFFSET = 16'h0002;
    localparam logic [15:0] VECTOR_RST = 16'h0100;
    localparam logic [15:0] VECTOR_MASK = 16'hfffc;

    // control_status_word bit positions
    localparam int CSW_GO = 0;
    localparam int CSW_IE = 6;
    localparam int CSW_DONE = 7;
    localparam int CSW_ERR = 15;

    // apb register byte addresses
    localparam logic [APB_AW-1:0] RA_EVENT = 8'h00;
    localparam logic [APB_AW-1:0] RA_MASK = 8'h04;
    localparam logic [APB_AW-1:0] RA_BASE = 8'h08;
    localparam logic [APB_AW-1:0] RA_VECTOR = 8'h0c;
    localparam logic [APB_AW-1:0] RA_DEVICE = 8'h10;
    localparam logic [APB_AW-1:0] RA_DATA = 8'h14;

    // event bit positions
    localparam int EV_BUS_WRITE = 0;
    localparam int EV_BUS_READ = 1;
    localparam int EV_VECTOR = 2;
    localparam int EV_GO = 3;
    localparam int EV_N = 4;

    // device register bit positions
    localparam int DEV_SET_DONE = 0;
    localparam int DEV_SET_ERR = 1;
    localparam int DEV_CLR_ERR = 2;

    typedef enum logic [1:0] {
        IOPD_IDLE = 2'b00,
        IOPD_ADDR = 2'b01,
        IOPD_XFER = 2'b10,
        IOPD_VEC = 2'b11
    } iopd_phase_t;

    typedef enum logic [1:0] {
        IOPD_SEL_NONE = 2'b00,
        IOPD_SEL_CSW = 2'b01,
        IOPD_SEL_DBUF = 2'b10
    } iopd_sel_t;

endpackage : iopd_pkg

// >>> testbench/iopd_sva.sv
// assertion checker for the i/o page slave ports
`timescale 1ns/1ps
module iopd_sva (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // backplane
    input wire logic i_bus_sync,
    input wire logic i_bus_din,
    input wire logic i_bus_dout,
    input wire logic i_bus_iak_in,
    input wire logic o_bus_reply,
    input wire logic o_bus_irq,
    input wire logic o_bus_iak_out,
    input wire logic [iopd_pkg::ADDR_W-1:0] o_muxed_addr_data_lines,
    input wire logic o_muxed_addr_data_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_ack;
        o_bus_irq && i_bus_iak_in && i_bus_din && !i_bus_sync;
    endsequence
    sequence s_vec;
        o_bus_reply && o_muxed_addr_data_oe && !o_bus_irq;
    endsequence
    a_vec_reply: assert property (s_ack |=> s_vec) else $error("no vector reply");
    a_vec_align: assert property (o_muxed_addr_data_oe && !i_bus_sync |-> o_muxed_addr_data_lines[1:0] == 2'b00)
        else $error("vector unaligned");
    a_grant_block: assert property (o_bus_irq |-> !o_bus_iak_out) else $error("grant passed on");
    a_apb_answer: assert property (i_psel && i_penable && !o_pready |-> ##[1:2] o_pready)
        else $error("apb no ready");
    a_apb_noerr: assert property (!o_pslverr) else $error("apb error");
    a_oe_reply: assert property (o_muxed_addr_data_oe |-> o_bus_reply) else $error("drive without reply");
    a_idle_zero: assert property (!o_muxed_addr_data_oe |-> o_muxed_addr_data_lines == '0)
        else $error("lines not idle");
    a_reply_drop: assert property (o_bus_reply && !i_bus_din && !i_bus_dout |=> !o_bus_reply)
        else $error("reply held");
endmodule : iopd_sva
bind iopd_top iopd_sva chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_bus_sync(i_bus_sync), .i_bus_din(i_bus_din),
    .i_bus_dout(i_bus_dout), .i_bus_iak_in(i_bus_iak_in), .o_bus_reply(o_bus_reply), .o_bus_irq(o_bus_irq),
    .o_bus_iak_out(o_bus_iak_out), .o_muxed_addr_data_lines(o_muxed_addr_data_lines),
    .o_muxed_addr_data_oe(o_muxed_addr_data_oe));

// >>> testbench/iopd_cpu_model.sv
// processor model running backplane cycles
`timescale 1ns/1ps
module iopd_cpu_model (
    // clock
    input wire logic i_clk,
    // backplane
    output logic [iopd_pkg::ADDR_W-1:0] o_lines,
    output logic o_sel_n,
    output logic o_sync,
    output logic o_din,
    output logic o_dout,
    output logic o_byte,
    output logic o_iak,
    input wire logic i_reply,
    input wire logic [iopd_pkg::ADDR_W-1:0] i_bus
);
    initial begin
        o_lines = '0;
        o_sel_n = 1'b1;
        o_sync = 1'b0;
        o_din = 1'b0;
        o_dout = 1'b0;
        o_byte = 1'b0;
        o_iak = 1'b0;
    end
    // bounded wait, a missing reply is a refusal
    task automatic await(output logic [15:0] q, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        while (!ok && n < 8) begin
            @(posedge i_clk);
            ok = (i_reply === 1'b1);
            n++;
        end
        q = i_bus[15:0];
        o_din <= 1'b0;
        o_dout <= 1'b0;
        o_iak <= 1'b0;
        o_lines <= ~o_lines;
        repeat (2) @(posedge i_clk);
    endtask : await
    task automatic cyc(input logic [17:0] a, input logic io, input logic rd, input logic [15:0] wd,
                       input logic bt, output logic [15:0] q, output logic ok);
        @(posedge i_clk);
        o_lines <= a;
        o_sel_n <= !io;
        o_sync <= 1'b1;
        o_byte <= bt;
        @(posedge i_clk);
        o_lines <= rd ? ~a : {2'b00, wd};
        o_din <= rd;
        o_dout <= !rd;
        await(q, ok);
        o_sync <= 1'b0;
        o_sel_n <= 1'b1;
    endtask : cyc
    task automatic iack(output logic [15:0] q, output logic ok);
        repeat (3) @(posedge i_clk);
        o_din <= 1'b1;
        o_iak <= 1'b1;
        await(q, ok);
    endtask : iack
endmodule : iopd_cpu_model

// >>> testbench/tb.sv
// self-checking bench for the i/o page slave
`timescale 1ns/1ps
module tb;
    import iopd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, serr, sn, sy, di, do_, bt, ia, rp, oe, birq, iao, irq;
    logic [APB_AW-1:0] pa = '0;
    logic [APB_DW-1:0] pwd = '0, prd;
    logic [ADDR_W-1:0] cl, dl, bus;
    logic [31:0] expq[$];
    int err_count = 0, checks = 0;
    assign bus = oe ? dl : cl;
    always #5 clk = ~clk;
    iopd_top dut_u (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(serr),
        .i_muxed_addr_data_lines(bus), .o_muxed_addr_data_lines(dl), .o_muxed_addr_data_oe(oe),
        .i_io_page_select_n(sn), .i_bus_sync(sy), .i_bus_din(di), .i_bus_dout(do_), .i_bus_byte(bt),
        .o_bus_reply(rp), .o_bus_irq(birq), .i_bus_iak_in(ia), .o_bus_iak_out(iao), .o_irq(irq));
    iopd_cpu_model cpu_u (.i_clk(clk), .o_lines(cl), .o_sel_n(sn), .o_sync(sy), .o_din(di),
        .o_dout(do_), .o_byte(bt), .o_iak(ia), .i_reply(rp), .i_bus(bus));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // no own limit: only the watchdog ends a wait for pready
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        apb(1'b0, a, '0);
    endtask : rd
    // monitor pairs each completed read with the oldest note
    always @(posedge clk) begin
        if (psel && pen && rdy === 1'b1 && !pwr && expq.size() > 0) chk(prd, expq.pop_front());
    end
    initial begin
        logic [15:0] w, q, v;
        logic [7:0] b;
        logic ok;
        void'($urandom(25));
        w = 16'($urandom);
        b = 8'($urandom);
        v = 16'($urandom) & VECTOR_MASK & 16'h01fc;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(RA_MASK, 32'h0);
        rd(RA_BASE, 32'h0000f100);
        rd(RA_VECTOR, 32'h00000100);
        rd(8'h18, 32'h0);
        $display("reset values test done");
        cpu_u.cyc({2'b00, BASE_ADDR_RST + DBUF_OFFSET}, 1'b1, 1'b0, w, 1'b0, q, ok);
        chk(32'(ok), 32'h1);
        chk(32'(irq), 32'h0);
        apb(1'b1, RA_MASK, 32'h1);
        chk(32'(irq), 32'h1);
        rd(RA_EVENT, 32'h1);
        chk(32'(irq), 32'h0);
        // upper lines 17:16 set: must still match
        cpu_u.cyc({2'b11, BASE_ADDR_RST + 16'h0003}, 1'b1, 1'b0, {b, 8'h00}, 1'b1, q, ok);
        rd(RA_DATA, {16'h0, b, w[7:0]});
        $display("word and byte test done");
        cpu_u.cyc({2'b00, BASE_ADDR_RST + DBUF_OFFSET}, 1'b0, 1'b1, 16'h0, 1'b0, q, ok);
        chk(32'(ok), 32'h0);
        cpu_u.cyc({2'b00, BASE_ADDR_RST + 16'h0004}, 1'b1, 1'b1, 16'h0, 1'b0, q, ok);
        chk(32'(ok), 32'h0);
        $display("refusal test done");
        apb(1'b1, RA_VECTOR, {16'h0, v});
        cpu_u.cyc({2'b00, BASE_ADDR_RST}, 1'b1, 1'b0, 16'h0040, 1'b0, q, ok);
        apb(1'b1, RA_DEVICE, 32'h1);
        // request rises one edge after done, so let that edge settle first
        @(posedge clk);
        chk(32'(birq), 32'h1);
        cpu_u.iack(q, ok);
        chk({15'h0, ok, q}, {16'h1, v});
        chk(32'(birq), 32'h0);
        apb(1'b1, RA_DEVICE, 32'h2);
        cpu_u.cyc({2'b00, BASE_ADDR_RST}, 1'b1, 1'b1, 16'h0, 1'b0, q, ok);
        chk({15'h0, ok, q}, {16'h1, 16'h80c0});
        $display("interrupt test done");
        chk(32'(expq.size()), 32'h0);
        end_of_test;
    end
    initial begin
        #200000;
        err_count++;
        end_of_test;
    end
endmodule : tb
